// File: scpc_pin_load.sv
// Purpose: far side of the shared pin
// Assumes: a pull of ext_level holds the line while released
// Notes: released line never keeps the last driven value
`timescale 1ns/1ps
module scpc_pin_load (
  input wire logic oe,
  input wire logic drive,
  input wire logic ext_level,
  output logic pin
);
  assign pin = oe ? drive : ext_level;
endmodule

// File: scpc_pkg.sv
// Purpose: constants for the sequence mask and shared pin config registers
// Assumes: byte-wide register addressing over the serial register port
// Notes: offsets are printed register addresses
package scpc_pkg;
  localparam logic [14:0] scpc_seq_mask_lo_addr = 15'h0024;
  localparam logic [14:0] scpc_seq_mask_hi_addr = 15'h0025;
  localparam logic [14:0] scpc_sequencer_control_addr = 15'h0022;
  localparam logic [14:0] scpc_io_enable_addr = 15'h0026;
  localparam logic [14:0] scpc_func_sel_addr = 15'h0027;
  localparam logic [14:0] scpc_pin_state_addr = 15'h0028;
  localparam logic [15:0] scpc_seq_mask_reset = 16'h0001;
  localparam logic [7:0] scpc_sequencer_control_reset = 8'h80;
  localparam logic [7:0] scpc_io_enable_reset = 8'h00;
  localparam logic [7:0] scpc_func_sel_reset = 8'h00;
  localparam logic [3:0] scpc_pin_level_reset = 4'h0;
  localparam int scpc_seq_en_bit = 7;
  localparam int scpc_in_en_bit = 4;
  localparam int scpc_out_en_bit = 0;
  localparam int scpc_mirror_bit = 7;
  localparam int scpc_busy_en_bit = 1;
  localparam int scpc_alert_en_bit = 0;
  localparam logic [7:0] scpc_io_enable_wmask = 8'hff;
  localparam logic [7:0] scpc_func_sel_wmask = 8'hbf;
  localparam logic [1:0] scpc_lane_dual = 2'b10;
  typedef enum logic [2:0] {
    scpc_pin_idle, scpc_pin_alert, scpc_pin_busy, scpc_pin_out, scpc_pin_in
  } scpc_pin_type;
endpackage

// File: scpc_props.sv
// Purpose: port checks for scpc_regs
// Assumes: derived outputs settle within two edges of a write
// Notes: bound from the bench
`timescale 1ns/1ps
module scpc_props
  import scpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [14:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic threshold_alert_indicator,
  input wire logic shared_multifunction_pin_oe,
  input wire logic [15:0] active_channel_mask,
  input wire logic standard_sequencer_enable,
  input wire logic serial_output_dual,
  input wire logic overvoltage_or_alert_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence func_wr;
    reg_wr && reg_addr == scpc_func_sel_addr;
  endsequence
  sequence func_rd;
    reg_rd && reg_addr == scpc_func_sel_addr;
  endsequence
  sequence recent_wr;
    $past(reg_wr) || $past(reg_wr, 2);
  endsequence
  seq_off_a: assert property (
    !standard_sequencer_enable && !$past(standard_sequencer_enable)
    |-> active_channel_mask == 16'h0000) else $error("mask not gated");
  lane_dual_a: assert property (
    func_wr ##0 reg_wdata[3:2] == 2'b10 |-> ##[1:2] serial_output_dual)
    else $error("dual lane not set");
  lane_cause_a: assert property (
    $changed(serial_output_dual) |-> recent_wr) else $error("lane moved");
  alert_pin_a: assert property (
    func_wr ##0 reg_wdata[0] |-> ##[1:2] shared_multifunction_pin_oe)
    else $error("alert not on pin");
  oe_cause_a: assert property (
    $changed(shared_multifunction_pin_oe) |-> recent_wr)
    else $error("pin enable moved");
  busy_pin_a: assert property (
    func_wr ##0 reg_wdata[1:0] == 2'b10 |->
    ##[1:2] shared_multifunction_pin_oe) else $error("busy not on pin");
  status_mirror_a: assert property (
    overvoltage_or_alert_status |-> $past(threshold_alert_indicator) ||
    $past(threshold_alert_indicator, 2)) else $error("status without alert");
  unmapped_read_a: assert property (
    reg_rd && reg_addr > scpc_pin_state_addr |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_bit_a: assert property (
    func_rd |=> !reg_rdata[6]) else $error("reserved bit set");
endmodule

// File: scpc_regs.sv
// Purpose: sequence mask and shared pin configuration registers
// Assumes: one register access per cycle from the serial interface decoder
// Notes: pin owner decided by a fixed priority each cycle
// How it works
// - mask bit n puts input n in the sequence while the sequencer runs.
// - the channel mask at 0x024 resets to 0x0001.
// - io enable bit 4 makes the shared pin an input if nothing higher.
// - io enable bit 0 makes the shared pin an output if nothing higher.
// - function bit 7 mirrors the threshold alert into the status bit.
// - output mode field [3:2] selects dual lanes only for binary 10.
// - function bit 1 puts busy on the pin if nothing higher is on.
// - function bit 0 puts alert on the pin if nothing higher is on.
// - the io enable register at 0x026 resets to 0x00.
// - the function register at 0x027 resets to 0x00.
// - the mask counts only while sequencer control bit 7 is set.
// - as output the pin follows bit 0 of the output level field.
// - as input the sampled pin shows in the low input level bit.
`timescale 1ns/1ps
module scpc_regs
  import scpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [14:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic conversion_busy,
  input wire logic threshold_alert_indicator,
  input wire logic shared_multifunction_pin_in,
  output logic shared_multifunction_pin_out,
  output logic shared_multifunction_pin_oe,
  output logic [15:0] active_channel_mask,
  output logic standard_sequencer_enable,
  output logic serial_output_dual,
  output logic overvoltage_or_alert_status
);
  logic [15:0] standard_sequence_channel_mask;
  logic [7:0] sequencer_control;
  logic [7:0] shared_pin_io_enable;
  logic [7:0] shared_pin_function_select;
  logic [3:0] pin_output_level_field;
  logic pin_in_q;
  logic [7:0] next_rdata;
  logic next_pin_out;
  logic next_pin_oe;
  scpc_pin_type pin_owner;

  function automatic logic hit(input logic [14:0] a, input logic [14:0] r);
    return a == r;
  endfunction

  wire wr_mask_lo = reg_wr && hit(reg_addr, scpc_seq_mask_lo_addr);
  wire wr_mask_hi = reg_wr && hit(reg_addr, scpc_seq_mask_hi_addr);
  wire wr_ctrl = reg_wr && hit(reg_addr, scpc_sequencer_control_addr);
  wire wr_io = reg_wr && hit(reg_addr, scpc_io_enable_addr);
  wire wr_func = reg_wr && hit(reg_addr, scpc_func_sel_addr);
  wire wr_state = reg_wr && hit(reg_addr, scpc_pin_state_addr);

  wire seq_on = sequencer_control[scpc_seq_en_bit];
  wire alert_on = shared_pin_function_select[scpc_alert_en_bit];
  wire busy_on = shared_pin_function_select[scpc_busy_en_bit];
  wire out_on = shared_pin_io_enable[scpc_out_en_bit];
  wire in_on = shared_pin_io_enable[scpc_in_en_bit];
  wire [1:0] lane_field = shared_pin_function_select[3:2];

  // fixed priority resolves overlapping enables
  assign pin_owner = alert_on ? scpc_pin_alert :
                     busy_on ? scpc_pin_busy :
                     out_on ? scpc_pin_out :
                     in_on ? scpc_pin_in :
                     scpc_pin_idle;

  always_comb begin
    next_pin_out = 1'b0;
    next_pin_oe = 1'b0;
    case (pin_owner)
      scpc_pin_alert: begin
        next_pin_out = threshold_alert_indicator;
        next_pin_oe = 1'b1;
      end
      scpc_pin_busy: begin
        next_pin_out = conversion_busy;
        next_pin_oe = 1'b1;
      end
      scpc_pin_out: begin
        next_pin_out = pin_output_level_field[0];
        next_pin_oe = 1'b1;
      end
      scpc_pin_in: begin
        next_pin_oe = 1'b0;
      end
      default: begin
        next_pin_oe = 1'b0;
      end
    endcase
  end

  // input level reads zero unless the pin is really an input
  wire in_level = (pin_owner == scpc_pin_in) & pin_in_q;

  always_comb begin
    next_rdata = 8'h00;
    if (hit(reg_addr, scpc_seq_mask_lo_addr)) begin
      next_rdata = standard_sequence_channel_mask[7:0];
    end else if (hit(reg_addr, scpc_seq_mask_hi_addr)) begin
      next_rdata = standard_sequence_channel_mask[15:8];
    end else if (hit(reg_addr, scpc_sequencer_control_addr)) begin
      next_rdata = sequencer_control;
    end else if (hit(reg_addr, scpc_io_enable_addr)) begin
      next_rdata = shared_pin_io_enable;
    end else if (hit(reg_addr, scpc_func_sel_addr)) begin
      next_rdata = shared_pin_function_select;
    end else if (hit(reg_addr, scpc_pin_state_addr)) begin
      next_rdata = {3'h0, in_level, pin_output_level_field};
    end
  end

  // read-only bits are cleared on the way in so they always read zero
  wire [7:0] io_wdata = reg_wdata & scpc_io_enable_wmask;
  wire [7:0] func_wdata = reg_wdata & scpc_func_sel_wmask;
  wire [15:0] next_active_mask = seq_on ?
    standard_sequence_channel_mask : 16'h0000;
  wire next_lane_dual = (lane_field == scpc_lane_dual);
  // with mirroring off the status bit must not follow the alert
  wire next_status = shared_pin_function_select[scpc_mirror_bit] &
    threshold_alert_indicator;

  // the two mask bytes sit at separate addresses, written independently
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      standard_sequence_channel_mask <= scpc_seq_mask_reset;
    end else begin
      if (wr_mask_lo) begin
        standard_sequence_channel_mask[7:0] <= reg_wdata;
      end
      if (wr_mask_hi) begin
        standard_sequence_channel_mask[15:8] <= reg_wdata;
      end
    end
  end

  // only bit 7 acts here; the slot count is kept for the sequencer engine
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sequencer_control <= scpc_sequencer_control_reset;
    end else if (wr_ctrl) begin
      sequencer_control <= reg_wdata;
    end
  end

  // reserved bits are stored but never decoded
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_pin_io_enable <= scpc_io_enable_reset;
    end else if (wr_io) begin
      shared_pin_io_enable <= io_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_pin_function_select <= scpc_func_sel_reset;
    end else if (wr_func) begin
      shared_pin_function_select <= func_wdata;
    end
  end

  // the upper nibble of the pin state address is the read-only input field
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_output_level_field <= scpc_pin_level_reset;
    end else if (wr_state) begin
      pin_output_level_field <= reg_wdata[3:0];
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // one sample flop: the pin reaches a read two cycles after it moves
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_in_q <= 1'b0;
    end else begin
      pin_in_q <= shared_multifunction_pin_in;
    end
  end

  // registered drive adds a cycle of lag but keeps the pin glitch free
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_multifunction_pin_out <= 1'b0;
      shared_multifunction_pin_oe <= 1'b0;
    end else begin
      shared_multifunction_pin_out <= next_pin_out;
      shared_multifunction_pin_oe <= next_pin_oe;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_channel_mask <= 16'h0000;
      standard_sequencer_enable <= 1'b0;
    end else begin
      active_channel_mask <= next_active_mask;
      standard_sequencer_enable <= seq_on;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_output_dual <= 1'b0;
      overvoltage_or_alert_status <= 1'b0;
    end else begin
      serial_output_dual <= next_lane_dual;
      overvoltage_or_alert_status <= next_status;
    end
  end
endmodule

// File: seq_channel_and_gp_pin_config_test.sv
// Purpose: self-checking bench for scpc_regs
// Assumes: read data one edge after the strobe
// Notes: inputs move at falling edges
`timescale 1ns/1ps
module seq_channel_and_gp_pin_config_test;
  import scpc_pkg::*;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [14:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, exp_q[$];
  logic busy = 0, alert = 0, ext = 1, pin, p_out, p_oe, seq_en, dual, st;
  logic exp_oe, exp_pin, exp_in;
  logic [15:0] mask;
  logic [31:0] rs = 5;
  int err_count = 0, num_checks = 0, cyc = 0;
  scpc_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conversion_busy(busy),
    .threshold_alert_indicator(alert), .shared_multifunction_pin_in(pin),
    .shared_multifunction_pin_out(p_out), .shared_multifunction_pin_oe(p_oe),
    .active_channel_mask(mask), .standard_sequencer_enable(seq_en),
    .serial_output_dual(dual), .overvoltage_or_alert_status(st));
  scpc_pin_load far (.oe(p_oe), .drive(p_out), .ext_level(ext), .pin(pin));
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] nxt(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_rd(logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] rdata exp %h got %h", e, g);
    end
  endtask
  task automatic wr(logic [14:0] a, logic [7:0] d);
    @(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge ref_clk) reg_wr = 0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic rd(logic [14:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(negedge ref_clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge ref_clk) reg_rd = 0;
    @(negedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rd_q) begin
      chk_rd(exp_q.pop_front(), reg_rdata);
    end
    rd_q <= reg_rd;
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 0;
    rd(scpc_seq_mask_lo_addr, 8'h01);
    rd(scpc_seq_mask_hi_addr, 8'h00);
    rd(scpc_io_enable_addr, 8'h00);
    rd(scpc_func_sel_addr, 8'h00);
    rd(scpc_sequencer_control_addr, 8'h80);
    rd(15'h0030, 8'h00);
    chk("mask", 16'h0001, mask);
    chk("seq_en", 16'h0001, 16'(seq_en));
    rs = nxt(rs);
    wr(scpc_seq_mask_lo_addr, rs[7:0]);
    wr(scpc_seq_mask_hi_addr, rs[15:8]);
    chk("mask", rs[15:0], mask);
    wr(scpc_sequencer_control_addr, 8'h00);
    chk("mask", 16'h0000, mask);
    chk("seq_en", 16'h0000, 16'(seq_en));
    wr(scpc_sequencer_control_addr, 8'h80);
    chk("mask", rs[15:0], mask);
    rd(scpc_seq_mask_hi_addr, rs[15:8]);
    wr(scpc_func_sel_addr, 8'hff);
    rd(scpc_func_sel_addr, 8'hbf);
    for (int i = 0; i < 4; i++) begin
      wr(scpc_func_sel_addr, {4'h0, i[1:0], 2'b00});
      chk("dual", 16'(i == 2), 16'(dual));
    end
    // reserved enable bits are stored but must not claim the pin
    wr(scpc_io_enable_addr, 8'hee);
    chk("oe", 16'h0000, 16'(p_oe));
    rd(scpc_io_enable_addr, 8'hee);
    // every mix of the four pin functions, random levels on the sources
    for (int k = 0; k < 16; k++) begin
      rs = nxt(rs);
      {ext, busy, alert} = rs[6:4];
      // the high nibble is read-only, so random high bits must not stick
      wr(scpc_pin_state_addr, rs[7:0]);
      wr(scpc_io_enable_addr, {3'h0, k[3], 3'h0, k[2]});
      wr(scpc_func_sel_addr, {6'h00, k[1:0]});
      exp_oe = |k[2:0];
      exp_pin = k[0] ? alert : k[1] ? busy : rs[0];
      exp_in = k[3] && !exp_oe && ext;
      chk("oe", 16'(exp_oe), 16'(p_oe));
      if (exp_oe) chk("pin", 16'(exp_pin), 16'(pin));
      rd(scpc_pin_state_addr, {3'h0, exp_in, rs[3:0]});
    end
    for (int m = 0; m < 4; m++) begin
      wr(scpc_func_sel_addr, {m[1], 7'h00});
      @(negedge ref_clk) alert = m[0];
      repeat (3) @(negedge ref_clk);
      chk("status", 16'(m[1] & m[0]), 16'(st));
    end
    // a reset in mid-run must bring the mask, io enable, function, oe and status defaults back
    @(negedge ref_clk) sys_rst = 1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 0;
    rd(scpc_seq_mask_lo_addr, 8'h01);
    rd(scpc_io_enable_addr, 8'h00);
    rd(scpc_func_sel_addr, 8'h00);
    chk("mask", 16'h0001, mask);
    chk("oe", 16'h0000, 16'(p_oe));
    chk("status", 16'h0000, 16'(st));
    wrap_up();
  end
endmodule
bind scpc_regs scpc_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .threshold_alert_indicator(threshold_alert_indicator),
  .shared_multifunction_pin_oe(shared_multifunction_pin_oe),
  .active_channel_mask(active_channel_mask),
  .standard_sequencer_enable(standard_sequencer_enable),
  .serial_output_dual(serial_output_dual),
  .overvoltage_or_alert_status(overvoltage_or_alert_status));
